// [design/dtmfsr_pkg.sv]
// Purpose: Constants and types for the DTMF code serial readout back end
// Assumes: ref_clk at 125 MHz, tone detector front end supplies row/column hits
// Notes: Times in microseconds, cycle counts derived from the clock rate
package dtmfsr_pkg;
    localparam int CLK_KHZ = 125000;
    localparam int REF_HZ = 4194304;
    localparam int PRESENT_US = 10000;
    localparam int ABSENT_US = 1000;
    localparam int GAP_US = 40000;
    localparam int VALID_US = 15000;
    localparam int PRESENT_CYC = PRESENT_US * (CLK_KHZ / 1000);
    localparam int ABSENT_CYC = ABSENT_US * (CLK_KHZ / 1000);
    localparam int GAP_CYC = GAP_US * (CLK_KHZ / 1000);
    localparam int VALID_CYC = VALID_US * (CLK_KHZ / 1000);
    localparam int CODE_W = 4;
    localparam int SHIFT_PULSES = 4;
    localparam logic [3:0] CODE_RESET = 4'h0;

    typedef struct packed {
        logic [3:0] low_hit;
        logic [3:0] high_hit;
    } dtmfsr_tone_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PEND = 4'b0010,
        ST_ON = 4'b0100,
        ST_OFF = 4'b1000
    } dtmfsr_state_t;

    // Row 0..3 = 697,770,852,941 Hz; column 0..3 = 1209,1336,1477,1633 Hz
    function automatic logic [3:0] dtmfsr_encode(input logic [1:0] row, input logic [1:0] col);
        logic [3:0] c;
        c = 4'h0;
        if (col == 2'd3) begin
            c = (row == 2'd3) ? 4'h0 : 4'(4'hd + {2'b00, row});
        end else if (row == 2'd3) begin
            case (col)
                2'd0: c = 4'hb;
                2'd1: c = 4'ha;
                default: c = 4'hc;
            endcase
        end else begin
            c = 4'({2'b00, row} * 4'd3 + {2'b00, col} + 4'd1);
        end
        return c;
    endfunction : dtmfsr_encode
endpackage : dtmfsr_pkg

// [design/dtmfsr_fifo.sv]
// Purpose: Small flip-flop FIFO for decoded key codes
// Assumes: Single clock, synchronous active high reset
// Notes: Depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module dtmfsr_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("dtmfsr_fifo: bad WIDTH or DEPTH");
        end
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    always_ff @(posedge ref_clk) begin
        if (do_wr) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(do_wr);
            rd_q <= rd_q + (AW+1)'(do_rd);
        end
    end
endmodule : dtmfsr_fifo
`default_nettype wire

// [design/dtmfsr_top.sv]
// Purpose: Key code decode, tone flags and serial readout
// Assumes: Front end gives one-hot row and column hits; shift clock synchronous
// Notes: No registers reachable by software
`timescale 1ns/1ps
`default_nettype none
module dtmfsr_top
    import dtmfsr_pkg::*;
#(
    parameter int PRESENT_CYCLES = dtmfsr_pkg::PRESENT_CYC,
    parameter int ABSENT_CYCLES = dtmfsr_pkg::ABSENT_CYC,
    parameter int GAP_CYCLES = dtmfsr_pkg::GAP_CYC,
    parameter int VALID_CYCLES = dtmfsr_pkg::VALID_CYC,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire dtmfsr_pkg::dtmfsr_tone_t tone_in,
    input wire logic shift_clk,
    input wire logic low_power_request,
    output logic serial_code_out,
    output logic early_tone_flag,
    output logic validated_tone_flag,
    output logic low_power_active,
    output logic code_overflow
);
    initial begin
        if (PRESENT_CYCLES < 1 || ABSENT_CYCLES < 1 || VALID_CYCLES <= PRESENT_CYCLES
            || GAP_CYCLES <= ABSENT_CYCLES) begin
            $error("dtmfsr_top: bad timing parameters");
        end
    end

    // ------------------------------------------------------------
    // Tone pair decode
    // ------------------------------------------------------------
    function automatic logic [1:0] idx4(input logic [3:0] h);
        return h[3] ? 2'd3 : h[2] ? 2'd2 : h[1] ? 2'd1 : 2'd0;
    endfunction : idx4
    function automatic logic one_hot(input logic [3:0] h);
        return (h != 4'h0) && ((h & (h - 4'h1)) == 4'h0);
    endfunction : one_hot

    wire pair_ok = one_hot(tone_in.low_hit) && one_hot(tone_in.high_hit) && !low_power_request;
    wire [3:0] pair_code = dtmfsr_encode(idx4(tone_in.low_hit), idx4(tone_in.high_hit));

    // ------------------------------------------------------------
    // Detection timers
    // ------------------------------------------------------------
    localparam int CW = $clog2(GAP_CYCLES + VALID_CYCLES + 2);
    dtmfsr_state_t state_q;
    dtmfsr_state_t state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] gap_q;
    logic [3:0] cand_q;
    logic [3:0] held_q;
    logic early_q;
    logic valid_q;
    logic lp_q;

    wire same_pair = pair_ok && (pair_code == cand_q);
    wire present_done = cnt_q >= CW'(PRESENT_CYCLES - 1);
    wire absent_done = cnt_q >= CW'(ABSENT_CYCLES - 1);
    wire gap_done = gap_q >= CW'(GAP_CYCLES - 1);
    wire valid_done = cnt_q >= CW'(VALID_CYCLES - 1);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: state_d = pair_ok ? ST_PEND : ST_IDLE;
            ST_PEND: begin
                if (!same_pair) begin
                    state_d = ST_IDLE;
                end else if (present_done && gap_done) begin
                    state_d = ST_ON;
                end
            end
            ST_ON: state_d = same_pair ? ST_ON : ST_OFF;
            ST_OFF: begin
                if (same_pair) begin
                    state_d = ST_ON;
                end else if (absent_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    wire enter_on = (state_q == ST_PEND) && (state_d == ST_ON);
    wire restart_cnt = (state_q != state_d) && !(state_q == ST_OFF && state_d == ST_ON);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            cand_q <= CODE_RESET;
        end else begin
            state_q <= state_d;
            cnt_q <= restart_cnt ? '0 : (&cnt_q ? cnt_q : cnt_q + CW'(1));
            cand_q <= (state_q == ST_IDLE) ? pair_code : cand_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gap_q <= CW'(GAP_CYCLES);
        end else if (state_q == ST_ON) begin
            gap_q <= '0;
        end else if (!gap_done) begin
            gap_q <= gap_q + CW'(1);
        end
    end

    // ------------------------------------------------------------
    // Flags and low power
    // ------------------------------------------------------------
    wire tone_on = (state_d == ST_ON) || (state_d == ST_OFF);
    wire early_rise = tone_on && !early_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            early_q <= 1'b0;
            valid_q <= 1'b0;
            lp_q <= 1'b0;
            held_q <= CODE_RESET;
        end else begin
            early_q <= tone_on;
            valid_q <= tone_on && (valid_q || (state_q == ST_ON && valid_done));
            lp_q <= low_power_request;
            held_q <= enter_on ? cand_q : held_q;
        end
    end

    // ------------------------------------------------------------
    // Code buffer
    // ------------------------------------------------------------
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [3:0] fifo_out_data;
    logic [3:0] head_q;
    logic head_valid_q;
    wire fifo_pop = fifo_out_valid && !head_valid_q;

    dtmfsr_fifo #(.WIDTH(CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(enter_on),
        .in_ready(fifo_in_ready),
        .in_data(cand_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------
    // Serial readout
    // ------------------------------------------------------------
    logic shift_q;
    logic [3:0] sreg_q;
    logic [2:0] pulses_q;
    logic overflow_q;
    wire shift_rise = shift_clk && !shift_q;
    wire shift_take = shift_rise && (pulses_q < 3'(SHIFT_PULSES)) && !early_rise;
    wire first_pulse = shift_take && (pulses_q == 3'd0);
    wire [3:0] latch_code = head_valid_q ? head_q : held_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shift_q <= 1'b0;
            sreg_q <= CODE_RESET;
            pulses_q <= 3'd0;
            head_q <= CODE_RESET;
            head_valid_q <= 1'b0;
            overflow_q <= 1'b0;
        end else begin
            shift_q <= shift_clk;
            overflow_q <= overflow_q || (enter_on && !fifo_in_ready);
            if (early_rise) begin
                pulses_q <= 3'd0;
            end else if (shift_take) begin
                pulses_q <= pulses_q + 3'd1;
            end
            if (first_pulse) begin
                sreg_q <= latch_code;
            end else if (shift_take) begin
                sreg_q <= {1'b0, sreg_q[3:1]};
            end
            if (fifo_pop) begin
                head_q <= fifo_out_data;
                head_valid_q <= 1'b1;
            end else if (first_pulse) begin
                head_valid_q <= 1'b0;
            end
        end
    end

    assign serial_code_out = sreg_q[0];
    assign early_tone_flag = early_q;
    assign validated_tone_flag = valid_q;
    assign low_power_active = lp_q;
    assign code_overflow = overflow_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_early_on_tone: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_ON) |-> early_tone_flag)
        else $error("early flag low during tone");
    chk_valid_after_early: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(validated_tone_flag) |-> $past(early_tone_flag))
        else $error("validated flag rose before early flag");
    chk_latch_first: assert property (@(posedge ref_clk) disable iff (rst)
        first_pulse |=> (sreg_q == $past(latch_code)))
        else $error("code not latched on first pulse");
    chk_shift_lsb: assert property (@(posedge ref_clk) disable iff (rst)
        (shift_take && !first_pulse) |=> (serial_code_out == $past(sreg_q[1])))
        else $error("shift did not advance one bit");
    chk_fifth_ignored: assert property (@(posedge ref_clk) disable iff (rst)
        (pulses_q == 3'd4 && !early_rise) |=> $stable(sreg_q))
        else $error("fifth pulse changed output");
    chk_pulse_limit: assert property (@(posedge ref_clk) disable iff (rst)
        pulses_q <= 3'd4)
        else $error("pulse count above four");
    chk_lowpower_follow: assert property (@(posedge ref_clk) disable iff (rst)
        low_power_request |=> low_power_active)
        else $error("low power not entered");
    chk_lowpower_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        low_power_request [*2] |=> (state_q == ST_IDLE || state_q == ST_OFF))
        else $error("tone tracked in low power");
    chk_gap_before_on: assert property (@(posedge ref_clk) disable iff (rst)
        enter_on |-> gap_done)
        else $error("key accepted inside inter-digit gap");
    chk_present_time: assert property (@(posedge ref_clk) disable iff (rst)
        enter_on |-> present_done)
        else $error("tone accepted too early");
    chk_serial_bit: assert property (@(posedge ref_clk) disable iff (rst)
        first_pulse |=> (serial_code_out == $past(latch_code[0])))
        else $error("bit zero not shown first");
    chk_early_tracks_state: assert property (@(posedge ref_clk) disable iff (rst)
        early_tone_flag == (state_q == ST_ON || state_q == ST_OFF))
        else $error("early flag does not follow tone state");
    chk_valid_needs_early: assert property (@(posedge ref_clk) disable iff (rst)
        validated_tone_flag |-> early_tone_flag)
        else $error("validated flag high without early flag");
    chk_early_leads_valid: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(early_tone_flag) |-> !validated_tone_flag)
        else $error("validated flag high at early rise");
    chk_valid_wait: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_ON && !valid_done && !validated_tone_flag) |=> !validated_tone_flag)
        else $error("validated flag rose too soon");
    chk_pend_short: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_PEND && !present_done) |=> !early_tone_flag)
        else $error("early flag before presence time");
    chk_gap_blocks_key: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_PEND && !gap_done) |=> !early_tone_flag)
        else $error("early flag inside inter-digit gap");
    chk_absence_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_OFF && !same_pair && !absent_done) |=> early_tone_flag)
        else $error("early flag fell before absence time");
    chk_absence_drop: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_OFF && !same_pair && absent_done) |=> !early_tone_flag)
        else $error("early flag held past absence time");
    chk_lowpower_block: assert property (@(posedge ref_clk) disable iff (rst)
        low_power_request |-> !enter_on)
        else $error("key accepted in low power");
    chk_lowpower_exit: assert property (@(posedge ref_clk) disable iff (rst)
        !low_power_request |=> !low_power_active)
        else $error("low power not left");
    chk_pulse_clear: assert property (@(posedge ref_clk) disable iff (rst)
        early_rise |=> (pulses_q == 3'd0))
        else $error("pulse count not cleared on early rise");
    chk_pulse_step: assert property (@(posedge ref_clk) disable iff (rst)
        shift_take |=> (pulses_q == $past(pulses_q) + 3'd1))
        else $error("pulse count did not step");
    chk_shift_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !shift_take |=> $stable(serial_code_out))
        else $error("serial output moved without a pulse");
    chk_head_consumed: assert property (@(posedge ref_clk) disable iff (rst)
        (first_pulse && !fifo_pop) |=> !head_valid_q)
        else $error("read code not consumed");
    chk_held_update: assert property (@(posedge ref_clk) disable iff (rst)
        enter_on |=> (held_q == $past(cand_q)))
        else $error("accepted code not held");

    // ------------------------------------------------------------
    // Code table checks
    // ------------------------------------------------------------
    chk_code_key_one: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_IDLE && tone_in.low_hit == 4'h1 && tone_in.high_hit == 4'h1)
        |=> (cand_q == 4'h1))
        else $error("key one code wrong");
    chk_code_key_nine: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_IDLE && tone_in.low_hit == 4'h4 && tone_in.high_hit == 4'h4)
        |=> (cand_q == 4'h9))
        else $error("key nine code wrong");
    chk_code_key_star: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_IDLE && tone_in.low_hit == 4'h8 && tone_in.high_hit == 4'h1)
        |=> (cand_q == 4'hb))
        else $error("star key code wrong");
    chk_code_key_hash: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_IDLE && tone_in.low_hit == 4'h8 && tone_in.high_hit == 4'h4)
        |=> (cand_q == 4'hc))
        else $error("hash key code wrong");
    chk_code_key_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_IDLE && tone_in.low_hit == 4'h1 && tone_in.high_hit == 4'h8)
        |=> (cand_q == 4'hd))
        else $error("key A code wrong");
    chk_code_key_d: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == ST_IDLE && tone_in.low_hit == 4'h8 && tone_in.high_hit == 4'h8)
        |=> (cand_q == 4'h0))
        else $error("key D code wrong");
endmodule : dtmfsr_top
`default_nettype wire

// [sim/dtmfsr_host_model.sv]
// Purpose: Host side model that clocks key codes out of the readout
// Assumes: Shift clock idles low, driven at falling edges of ref_clk
// Notes: Each half pulse lasts HALF cycles, keeping the rate under 1 MHz
`timescale 1ns/1ps
`default_nettype none
module dtmfsr_host_model #(
    parameter int HALF = 63
) (
    input wire logic ref_clk,
    input wire logic serial_code_out,
    output logic shift_clk
);
    // ----------------
    // Shift pulses
    // ----------------
    initial shift_clk = 1'b0;

    task automatic pulse(output logic b);
        @(negedge ref_clk) shift_clk = 1'b1;
        repeat (HALF) @(negedge ref_clk);
        b = serial_code_out;
        shift_clk = 1'b0;
        repeat (HALF) @(negedge ref_clk);
    endtask : pulse

    task automatic read_code(output logic [3:0] c);
        repeat (8) @(negedge ref_clk); // Wait after early rise
        for (int i = 0; i < 4; i++) begin
            pulse(c[i]);
        end
    endtask : read_code
endmodule : dtmfsr_host_model
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the key code serial readout
// Assumes: Shortened detection counts, host model on the shift clock
// Notes: Inputs change at falling edges only
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dtmfsr_pkg::*;
    // ----------------
    // Setup
    // ----------------
    localparam int PC = 20;
    localparam int AC = 5;
    localparam int VC = 40;
    localparam int GC = 50;
    localparam logic [63:0] KEYS = 64'h0cab_f987_e654_d321;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic low_power_request = 1'b0;
    dtmfsr_tone_t tone = '0;
    wire logic shift_clk, serial_code_out, early_tone_flag;
    wire logic validated_tone_flag, low_power_active, code_overflow;
    int failures = 0;
    int n_tests = 0;

    always #4 ref_clk = ~ref_clk;

    dtmfsr_top #(.PRESENT_CYCLES(PC), .ABSENT_CYCLES(AC), .GAP_CYCLES(GC),
        .VALID_CYCLES(VC), .FIFO_DEPTH(32)) dut (
        .ref_clk(ref_clk), .rst(rst), .tone_in(tone), .shift_clk(shift_clk),
        .low_power_request(low_power_request), .serial_code_out(serial_code_out),
        .early_tone_flag(early_tone_flag), .validated_tone_flag(validated_tone_flag),
        .low_power_active(low_power_active), .code_overflow(code_overflow));

    dtmfsr_host_model host (.ref_clk(ref_clk), .serial_code_out(serial_code_out),
        .shift_clk(shift_clk));

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_code(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_code

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cycles

    task automatic wait_early(input logic lvl, input int lim, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge ref_clk);
            seen = (early_tone_flag === lvl);
        end
    endtask : wait_early

    task automatic put_key(input int k);
        @(negedge ref_clk);
        tone = {4'(1 << (k / 4)), 4'(1 << (k % 4))};
    endtask : put_key

    // ----------------
    // Scenarios
    // ----------------
    task automatic test_key(input int k);
        logic s;
        logic [3:0] c;
        put_key(k);
        wait_early(1'b1, PC + 3, s);
        chk_bit("early rise", 1'b1, s);
        chk_bit("validated at early rise", 1'b0, validated_tone_flag);
        host.read_code(c);
        chk_code("key code", KEYS[4*k +: 4], c);
        host.pulse(s);
        chk_bit("fifth pulse", KEYS[4*k+3], s);
        chk_bit("validated", 1'b1, validated_tone_flag);
        tone = '0;
        cycles(2);
        chk_bit("early hold", 1'b1, early_tone_flag);
        wait_early(1'b0, AC + 3, s);
        chk_bit("early fall", 1'b1, s);
        cycles(GC + 5);
        $display("test key %0d done", k);
    endtask : test_key

    task automatic test_burst();
        logic s;
        put_key(9);
        cycles(PC / 2);
        tone = '0;
        wait_early(1'b1, PC + 5, s);
        chk_bit("early after burst", 1'b0, s);
        put_key(0);
        wait_early(1'b1, PC + 3, s);
        chk_bit("early on short tone", 1'b1, s);
        cycles(VC / 2);
        chk_bit("validated on short tone", 1'b0, validated_tone_flag);
        tone = '0;
        wait_early(1'b0, AC + 3, s);
        chk_bit("short tone end", 1'b1, s);
        chk_bit("validated after short tone", 1'b0, validated_tone_flag);
        cycles(GC + 5);
        $display("test burst done");
    endtask : test_burst

    task automatic test_power();
        logic s;
        low_power_request = 1'b1;
        cycles(3);
        chk_bit("low_power_active", 1'b1, low_power_active);
        put_key(6);
        wait_early(1'b1, PC + 10, s);
        chk_bit("early in low power", 1'b0, s);
        tone = '0;
        low_power_request = 1'b0;
        cycles(3);
        chk_bit("low_power_active", 1'b0, low_power_active);
        $display("test power done");
    endtask : test_power

    task automatic test_gap();
        logic s;
        put_key(0);
        wait_early(1'b1, PC + 3, s);
        tone = '0;
        wait_early(1'b0, AC + 3, s);
        put_key(1);
        wait_early(1'b1, PC + 10, s);
        chk_bit("early in gap", 1'b0, s);
        tone = '0;
        cycles(GC + PC);
        chk_bit("code_overflow", 1'b0, code_overflow);
        $display("test gap done");
    endtask : test_gap

    task automatic test_fill();
        logic s;
        logic [3:0] c;
        for (int i = 0; i < 33; i++) begin
            put_key(i % 16);
            wait_early(1'b1, PC + 3, s);
            tone = '0;
            wait_early(1'b0, AC + 3, s);
            cycles(GC + 5);
        end
        chk_bit("code_overflow", 1'b1, code_overflow);
        host.read_code(c);
        chk_code("oldest code", KEYS[3:0], c);
        $display("test fill done");
    endtask : test_fill

    task automatic test_reset();
        logic [3:0] c;
        rst = 1'b1;
        cycles(6);
        rst = 1'b0;
        cycles(2);
        chk_bit("code_overflow after reset", 1'b0, code_overflow);
        chk_bit("early after reset", 1'b0, early_tone_flag);
        chk_bit("validated after reset", 1'b0, validated_tone_flag);
        chk_bit("serial after reset", 1'b0, serial_code_out);
        host.read_code(c);
        chk_code("code after reset", CODE_RESET, c);
        $display("test reset done");
    endtask : test_reset

    // ----------------
    // Sequence
    // ----------------
    initial begin
        cycles(7);
        rst = 1'b0;
        for (int k = 0; k < 16; k++) begin
            test_key(k);
        end
        test_burst();
        test_power();
        test_gap();
        test_fill();
        test_reset();
        close_out();
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        failures++;
        $display("mismatch watchdog expected done seen timeout");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
